// File: common/bps_pkg.sv
// Package for the board power state sequencer
`default_nettype none
package bps_pkg;
    localparam int unsigned BPS_CLK_HZ = 40000000;
    localparam int unsigned BPS_LONG_PRESS_MS = 2000;
    localparam int unsigned BPS_LONG_PRESS_CYC = BPS_CLK_HZ / 1000 * BPS_LONG_PRESS_MS;
    localparam int unsigned BPS_DEBOUNCE_US = 10000;
    localparam int unsigned BPS_DEBOUNCE_CYC = BPS_CLK_HZ / 1000000 * BPS_DEBOUNCE_US;
    localparam int unsigned BPS_CNT_W = 32;

    typedef enum logic [4:0] {
        BPS_ST_RESET = 5'h00,
        BPS_ST_READ_ID = 5'h01,
        BPS_ST_STANDBY = 5'h02,
        BPS_ST_READ_CFG = 5'h03,
        BPS_ST_FIND_DIR = 5'h04,
        BPS_ST_LOG_FAIL = 5'h05,
        BPS_ST_POWER_ON = 5'h06,
        BPS_ST_CLOCKS_ON = 5'h07,
        BPS_ST_PROC_BOOT = 5'h08,
        BPS_ST_MEASURE = 5'h09,
        BPS_ST_LOAD_FPGA = 5'h0A,
        BPS_ST_SET_OSC = 5'h0B,
        BPS_ST_FLASH = 5'h0C,
        BPS_ST_CFG_RST = 5'h0D,
        BPS_ST_CFG_PROG = 5'h0E,
        BPS_ST_OPERATING = 5'h0F,
        BPS_ST_PD_CLUSTER = 5'h10,
        BPS_ST_PD_DOMAINS = 5'h11,
        BPS_ST_PD_WAIT_RDY = 5'h12,
        BPS_ST_SL_CLUSTER = 5'h13,
        BPS_ST_SL_DOMAINS = 5'h14,
        BPS_ST_SLEEP = 5'h15,
        BPS_ST_WK_DOMAINS = 5'h16,
        BPS_ST_WK_SETUP = 5'h17,
        BPS_ST_WK_RESUME = 5'h18
    } bps_state_t;

    // Requests to outside agents; each one completes on the shared i_task_done input
    typedef struct packed {
        logic id_read;
        logic cfg_read;
        logic dir_find;
        logic log_write;
        logic supply_measure;
        logic fpga_load;
        logic osc_program;
        logic flash_write;
        logic cfg_program;
        logic resume_store;
    } bps_task_t;

    typedef struct packed {
        logic shutdown_req;
        logic sleep_req;
        logic clusters_on;
        logic ram_retain;
        logic ppu_release;
        logic setup_req;
    } bps_soc_ctl_t;
endpackage
`default_nettype wire

// File: design/bps_sequencer.sv
// Board power state sequencer top module
`default_nettype none
module bps_sequencer
    import bps_pkg::*;
#(
    parameter int unsigned LONG_PRESS_CYC = BPS_LONG_PRESS_CYC,
    parameter int unsigned DEBOUNCE_CYC = BPS_DEBOUNCE_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_power_button,
    input wire logic i_hw_reset_button,
    input wire logic i_restart_command,
    input wire logic i_os_powerdown_req,
    input wire logic i_db_fitted,
    input wire logic i_task_done,
    input wire logic i_dir_found,
    input wire logic i_proc_booted,
    input wire logic i_cluster_wfi_down,
    input wire logic i_domains_done,
    input wire logic i_ready_for_shutdown,
    output var bps_task_t o_task,
    output var bps_soc_ctl_t o_soc,
    output logic o_id_mem_power,
    output logic o_console_en,
    output logic o_card_access_en,
    output logic o_main_supply_en,
    output logic o_power_mgmt_en,
    output logic o_clocks_en,
    output logic o_config_block_reset_n,
    output logic o_board_poweron_reset_n,
    output logic o_board_system_reset_n,
    output var bps_state_t o_state
);
    bps_state_t state_reg, state_next;
    bps_task_t task_next;
    bps_soc_ctl_t soc_next;
    logic btn_sync_reg, btn_stable_reg, btn_prev_reg;
    logic [BPS_CNT_W-1:0] deb_cnt_reg, press_cnt_reg;
    logic long_fired_reg, long_press_reg, short_press_reg;
    logic press_go;

    // Debounce; a held button needs a steady level for DEBOUNCE_CYC
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            btn_sync_reg <= 1'b0;
            btn_stable_reg <= 1'b0;
            deb_cnt_reg <= '0;
        end else if (i_ce) begin
            btn_sync_reg <= i_power_button;
            if (btn_sync_reg == btn_stable_reg) begin
                deb_cnt_reg <= '0;
            end else if (deb_cnt_reg >= DEBOUNCE_CYC - 1) begin
                btn_stable_reg <= btn_sync_reg;
                deb_cnt_reg <= '0;
            end else begin
                deb_cnt_reg <= deb_cnt_reg + 1'b1;
            end
        end
    end

    // Long press fires at the threshold, so the holder need not release first
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            btn_prev_reg <= 1'b0;
            press_cnt_reg <= '0;
            long_fired_reg <= 1'b0;
            long_press_reg <= 1'b0;
            short_press_reg <= 1'b0;
        end else if (i_ce) begin
            btn_prev_reg <= btn_stable_reg;
            long_press_reg <= 1'b0;
            short_press_reg <= 1'b0;
            if (btn_stable_reg) begin
                if (!btn_prev_reg) begin
                    press_cnt_reg <= '0;
                    long_fired_reg <= 1'b0;
                end else if (!long_fired_reg) begin
                    if (press_cnt_reg >= LONG_PRESS_CYC - 1) begin
                        long_fired_reg <= 1'b1;
                        long_press_reg <= 1'b1;
                    end else begin
                        press_cnt_reg <= press_cnt_reg + 1'b1;
                    end
                end
            end else if (btn_prev_reg && !long_fired_reg) begin
                short_press_reg <= 1'b1;
            end
        end
    end

    // Only the press edge of a button press counts to leave standby
    assign press_go = btn_stable_reg && !btn_prev_reg;

    // No timeout on any handshake; a far side that never answers stalls the sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            BPS_ST_RESET: state_next = BPS_ST_READ_ID;
            BPS_ST_READ_ID: begin
                if (i_task_done) begin
                    state_next = BPS_ST_STANDBY;
                end
            end
            BPS_ST_STANDBY: begin
                if (press_go || i_restart_command) begin
                    state_next = BPS_ST_READ_CFG;
                end
            end
            BPS_ST_READ_CFG: begin
                if (i_task_done) begin
                    state_next = BPS_ST_FIND_DIR;
                end
            end
            BPS_ST_FIND_DIR: begin
                if (i_task_done && i_dir_found) begin
                    state_next = BPS_ST_POWER_ON;
                end else if (i_task_done) begin
                    state_next = BPS_ST_LOG_FAIL;
                end
            end
            BPS_ST_LOG_FAIL: begin
                if (i_task_done) begin
                    state_next = BPS_ST_STANDBY;
                end
            end

            // Power-up chain
            BPS_ST_POWER_ON: begin
                if (i_task_done) begin
                    state_next = BPS_ST_CLOCKS_ON;
                end
            end
            BPS_ST_CLOCKS_ON: state_next = BPS_ST_PROC_BOOT;
            BPS_ST_PROC_BOOT: begin
                if (i_proc_booted) begin
                    state_next = BPS_ST_MEASURE;
                end
            end
            BPS_ST_MEASURE: begin
                if (i_task_done) begin
                    state_next = BPS_ST_LOAD_FPGA;
                end
            end
            BPS_ST_LOAD_FPGA: begin
                if (i_task_done) begin
                    state_next = BPS_ST_SET_OSC;
                end
            end
            BPS_ST_SET_OSC: begin
                if (i_task_done) begin
                    state_next = BPS_ST_FLASH;
                end
            end
            BPS_ST_FLASH: begin
                if (i_task_done) begin
                    state_next = BPS_ST_CFG_RST;
                end
            end
            BPS_ST_CFG_RST: state_next = BPS_ST_CFG_PROG;
            BPS_ST_CFG_PROG: begin
                if (i_task_done) begin
                    state_next = BPS_ST_OPERATING;
                end
            end
            BPS_ST_OPERATING: begin
                if (long_press_reg || i_hw_reset_button || i_os_powerdown_req) begin
                    state_next = BPS_ST_PD_CLUSTER;
                end else if (short_press_reg) begin
                    state_next = BPS_ST_SL_CLUSTER;
                end
            end

            // Powerdown
            BPS_ST_PD_CLUSTER: begin
                if (i_cluster_wfi_down) begin
                    state_next = BPS_ST_PD_DOMAINS;
                end
            end
            BPS_ST_PD_DOMAINS: begin
                if (i_domains_done) begin
                    state_next = BPS_ST_PD_WAIT_RDY;
                end
            end
            BPS_ST_PD_WAIT_RDY: begin
                if (i_ready_for_shutdown) begin
                    state_next = BPS_ST_STANDBY;
                end
            end

            // Sleep and wake-up
            BPS_ST_SL_CLUSTER: begin
                if (i_cluster_wfi_down) begin
                    state_next = BPS_ST_SL_DOMAINS;
                end
            end
            BPS_ST_SL_DOMAINS: begin
                if (i_domains_done) begin
                    state_next = BPS_ST_SLEEP;
                end
            end
            BPS_ST_SLEEP: begin
                // Long press and reset button are ignored here; no path to standby
                if (short_press_reg) begin
                    state_next = BPS_ST_WK_DOMAINS;
                end
            end
            BPS_ST_WK_DOMAINS: begin
                if (i_domains_done) begin
                    state_next = BPS_ST_WK_SETUP;
                end
            end
            BPS_ST_WK_SETUP: begin
                if (i_proc_booted) begin
                    state_next = BPS_ST_WK_RESUME;
                end
            end
            BPS_ST_WK_RESUME: begin
                if (i_task_done) begin
                    state_next = BPS_ST_OPERATING;
                end
            end
            default: state_next = BPS_ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= BPS_ST_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // Requests are levels held until the state advances
    always_comb begin
        task_next = '0;
        soc_next = '0;
        case (state_next)
            BPS_ST_READ_ID: task_next.id_read = 1'b1;
            BPS_ST_READ_CFG: task_next.cfg_read = 1'b1;
            BPS_ST_FIND_DIR: task_next.dir_find = 1'b1;
            BPS_ST_LOG_FAIL: task_next.log_write = 1'b1;
            BPS_ST_MEASURE: task_next.supply_measure = 1'b1;
            BPS_ST_LOAD_FPGA: task_next.fpga_load = 1'b1;
            BPS_ST_SET_OSC: task_next.osc_program = 1'b1;
            BPS_ST_FLASH: task_next.flash_write = 1'b1;
            BPS_ST_CFG_PROG: task_next.cfg_program = 1'b1;
            BPS_ST_PD_CLUSTER: soc_next.shutdown_req = 1'b1;
            BPS_ST_SL_CLUSTER: soc_next.sleep_req = 1'b1;
            // Retention is asked for as soon as the domains start to go down
            BPS_ST_SL_DOMAINS, BPS_ST_SLEEP: soc_next.ram_retain = 1'b1;
            BPS_ST_WK_DOMAINS: begin
                soc_next.ram_retain = 1'b1;
                soc_next.clusters_on = 1'b1;
            end
            BPS_ST_WK_SETUP: begin
                soc_next.clusters_on = 1'b1;
                soc_next.setup_req = 1'b1;
            end
            BPS_ST_WK_RESUME: begin
                soc_next.clusters_on = 1'b1;
                task_next.resume_store = 1'b1;
            end
            BPS_ST_PROC_BOOT: soc_next.setup_req = 1'b1;
            default: ;
        endcase
        // Policy unit release only once boot or resume store is complete
        if (state_next inside {BPS_ST_MEASURE, BPS_ST_LOAD_FPGA, BPS_ST_SET_OSC, BPS_ST_FLASH,
                BPS_ST_CFG_RST, BPS_ST_CFG_PROG, BPS_ST_OPERATING}
                || (state_next == BPS_ST_OPERATING)) begin
            soc_next.ppu_release = 1'b1;
            soc_next.clusters_on = 1'b1;
        end
    end

    function automatic logic bps_powered(input bps_state_t s);
        bps_powered = !(s inside {BPS_ST_RESET, BPS_ST_READ_ID, BPS_ST_STANDBY, BPS_ST_READ_CFG,
            BPS_ST_FIND_DIR, BPS_ST_LOG_FAIL});
    endfunction

    function automatic logic bps_clocked(input bps_state_t s);
        bps_clocked = bps_powered(s) && (s != BPS_ST_POWER_ON);
    endfunction

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_task <= '0;
            o_soc <= '0;
            o_state <= BPS_ST_RESET;
        end else if (i_ce) begin
            o_task <= task_next;
            o_soc <= soc_next;
            o_state <= state_next;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_id_mem_power <= 1'b0;
            o_console_en <= 1'b0;
            o_card_access_en <= 1'b0;
        end else if (i_ce) begin
            o_id_mem_power <= (state_next == BPS_ST_READ_ID);
            o_console_en <= (state_next == BPS_ST_STANDBY);
            o_card_access_en <= (state_next == BPS_ST_STANDBY);
        end
    end

    // Supply leads clocks by one state so rails settle before clocking
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_main_supply_en <= 1'b0;
            o_power_mgmt_en <= 1'b0;
            o_clocks_en <= 1'b0;
        end else if (i_ce) begin
            o_main_supply_en <= bps_powered(state_next);
            o_power_mgmt_en <= bps_powered(state_next);
            o_clocks_en <= bps_clocked(state_next);
        end
    end

    // Config reset released first, then power-on and system resets together; powerdown drops them together
    // Config reset stays released through sleep so its settings survive wake-up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_config_block_reset_n <= 1'b0;
            o_board_poweron_reset_n <= 1'b0;
            o_board_system_reset_n <= 1'b0;
        end else if (i_ce) begin
            o_config_block_reset_n <= state_next inside {BPS_ST_CFG_RST, BPS_ST_CFG_PROG,
                BPS_ST_OPERATING} || (bps_clocked(state_next)
                && o_board_poweron_reset_n);
            o_board_poweron_reset_n <= (state_next == BPS_ST_OPERATING)
                || (bps_powered(state_next) && o_board_poweron_reset_n);
            o_board_system_reset_n <= (state_next == BPS_ST_OPERATING)
                || (bps_powered(state_next) && o_board_system_reset_n);
        end
    end
endmodule
`default_nettype wire

// File: test/bps_sequencer_chk.sv
// Concurrent checks on the sequencer ports
`default_nettype none
module bps_sequencer_chk
    import bps_pkg::*;
#(
    parameter int unsigned LONG_PRESS_CYC = 50,
    parameter int unsigned DEBOUNCE_CYC = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_restart_command,
    input wire logic i_os_powerdown_req,
    input wire logic i_task_done,
    input wire logic i_dir_found,
    input wire logic i_ready_for_shutdown,
    input var bps_task_t o_task,
    input var bps_soc_ctl_t o_soc,
    input wire logic o_power_mgmt_en,
    input wire logic o_main_supply_en,
    input wire logic o_clocks_en,
    input wire logic o_console_en,
    input wire logic o_card_access_en,
    input wire logic o_config_block_reset_n,
    input wire logic o_board_poweron_reset_n,
    input wire logic o_board_system_reset_n,
    input var bps_state_t o_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Bound is generous: the partner answers each step within a few cycles
    sequence s_log_then_standby;
        o_state == BPS_ST_LOG_FAIL ##[1:300] o_state == BPS_ST_STANDBY;
    endsequence
    sequence s_kept_asleep;
        o_soc.ram_retain ##1 o_state inside {BPS_ST_SLEEP, BPS_ST_WK_DOMAINS};
    endsequence
    chk_supply_first: assert property (
        o_clocks_en |-> o_main_supply_en && o_power_mgmt_en) else $error("clocks without supply");
    chk_cfg_prog_order: assert property (
        o_task.cfg_program |-> o_config_block_reset_n && $past(o_config_block_reset_n))
        else $error("config block programmed under reset");
    chk_cfg_after_load: assert property (
        $rose(o_config_block_reset_n) |-> $past(o_state) == BPS_ST_FLASH && o_soc.ppu_release)
        else $error("config reset released early");
    chk_por_last: assert property (
        $rose(o_board_poweron_reset_n) |-> o_board_system_reset_n
        && o_state == BPS_ST_OPERATING && $past(o_state) == BPS_ST_CFG_PROG)
        else $error("resets released out of order");
    chk_standby_outs: assert property (
        o_state == BPS_ST_STANDBY |-> o_console_en && o_card_access_en
        && !o_board_poweron_reset_n && !o_clocks_en && !o_power_mgmt_en)
        else $error("standby outputs wrong");
    chk_ready_down: assert property (
        o_state == BPS_ST_PD_WAIT_RDY && i_ce && i_ready_for_shutdown
        |=> o_state == BPS_ST_STANDBY) else $error("ready for shutdown not taken");
    chk_restart_leave: assert property (
        o_state == BPS_ST_STANDBY && i_ce && i_restart_command |=> o_state == BPS_ST_READ_CFG)
        else $error("restart did not leave standby");
    chk_dir_missing: assert property (
        o_state == BPS_ST_FIND_DIR && i_ce && i_task_done && !i_dir_found
        |=> s_log_then_standby) else $error("missing directory not logged");
    chk_os_request: assert property (
        o_state == BPS_ST_OPERATING && i_ce && i_os_powerdown_req
        |=> o_state == BPS_ST_PD_CLUSTER) else $error("os request ignored");
    chk_sleep_hold: assert property (
        o_state == BPS_ST_SLEEP |-> s_kept_asleep) else $error("sleep left wrongly");
    chk_policy_release: assert property (
        $rose(o_soc.ppu_release) |-> $past(o_state) inside {BPS_ST_PROC_BOOT, BPS_ST_WK_RESUME})
        else $error("policy units released early");
endmodule
bind bps_sequencer bps_sequencer_chk #(
    .LONG_PRESS_CYC(LONG_PRESS_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)
) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_restart_command(i_restart_command),
    .i_os_powerdown_req(i_os_powerdown_req), .i_task_done(i_task_done),
    .i_dir_found(i_dir_found), .i_ready_for_shutdown(i_ready_for_shutdown),
    .o_task(o_task), .o_soc(o_soc), .o_power_mgmt_en(o_power_mgmt_en),
    .o_main_supply_en(o_main_supply_en), .o_clocks_en(o_clocks_en),
    .o_console_en(o_console_en), .o_card_access_en(o_card_access_en),
    .o_config_block_reset_n(o_config_block_reset_n),
    .o_board_poweron_reset_n(o_board_poweron_reset_n),
    .o_board_system_reset_n(o_board_system_reset_n), .o_state(o_state)
);
`default_nettype wire

// File: test/bps_partner.sv
// Far-side agent answering every handshake after a set delay
`default_nettype none
module bps_partner
    import bps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input var bps_state_t i_state,
    input var bps_task_t i_task,
    input wire logic [7:0] i_delay,
    input wire logic i_dir_ok,
    output logic o_task_done,
    output logic o_dir_found,
    output logic o_proc_booted,
    output logic o_cluster_wfi_down,
    output logic o_domains_done,
    output logic o_ready_for_shutdown
);
    logic [7:0] cnt_reg;
    bps_state_t last_reg;
    logic hit;
    assign hit = (cnt_reg == i_delay);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 8'h00;
            last_reg <= BPS_ST_RESET;
        end else begin
            last_reg <= i_state;
            cnt_reg <= (i_state != last_reg) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    // Answers are one-cycle pulses, or two cycles with zero delay after a one-cycle state; dir flag shows the inverse outside them
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_task_done <= 1'b0;
            o_dir_found <= 1'b0;
            o_proc_booted <= 1'b0;
            o_cluster_wfi_down <= 1'b0;
            o_domains_done <= 1'b0;
            o_ready_for_shutdown <= 1'b0;
        end else begin
            o_task_done <= hit && (i_task != '0 || i_state == BPS_ST_POWER_ON);
            o_dir_found <= hit ? i_dir_ok : !i_dir_ok;
            o_proc_booted <= hit && i_state inside {BPS_ST_PROC_BOOT, BPS_ST_WK_SETUP};
            o_cluster_wfi_down <= hit && i_state inside {BPS_ST_PD_CLUSTER, BPS_ST_SL_CLUSTER};
            o_domains_done <= hit && i_state inside {BPS_ST_PD_DOMAINS, BPS_ST_SL_DOMAINS,
                BPS_ST_WK_DOMAINS};
            o_ready_for_shutdown <= hit && i_state == BPS_ST_PD_WAIT_RDY;
        end
    end
endmodule
`default_nettype wire

// File: test/bps_sequencer_tb_top.sv
// Testbench for the board power state sequencer
`default_nettype none
module bps_sequencer_tb_top;
    import bps_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_rst, btn, hw_btn, restart, os_req, db_fit, dir_ok;
    logic t_done, d_found, booted, wfi_dn, dom_done, rdy;
    logic [7:0] delay;
    bps_task_t o_task;
    bps_soc_ctl_t o_soc;
    bps_state_t o_state;
    logic id_pwr, con_en, card_en, sup_en, pm_en, clk_en, cfg_n, por_n, sys_n;
    int fail_count, checks;
    bps_sequencer #(.LONG_PRESS_CYC(50), .DEBOUNCE_CYC(4)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_power_button(btn),
        .i_hw_reset_button(hw_btn), .i_restart_command(restart), .i_os_powerdown_req(os_req),
        .i_db_fitted(db_fit), .i_task_done(t_done), .i_dir_found(d_found),
        .i_proc_booted(booted), .i_cluster_wfi_down(wfi_dn), .i_domains_done(dom_done),
        .i_ready_for_shutdown(rdy), .o_task(o_task), .o_soc(o_soc), .o_id_mem_power(id_pwr),
        .o_console_en(con_en), .o_card_access_en(card_en), .o_main_supply_en(sup_en),
        .o_power_mgmt_en(pm_en), .o_clocks_en(clk_en), .o_config_block_reset_n(cfg_n),
        .o_board_poweron_reset_n(por_n), .o_board_system_reset_n(sys_n), .o_state(o_state));
    bps_partner u_far (.i_clk(i_clk), .i_rst(i_rst), .i_state(o_state), .i_task(o_task),
        .i_delay(delay), .i_dir_ok(dir_ok), .o_task_done(t_done), .o_dir_found(d_found),
        .o_proc_booted(booted), .o_cluster_wfi_down(wfi_dn), .o_domains_done(dom_done),
        .o_ready_for_shutdown(rdy));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task summarize;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Inputs always move 2 ns after the rising edge
    task tick(input int n);
        repeat (n) begin
            @(posedge i_clk);
            #2;
        end
    endtask
    task wait_st(input bps_state_t s);
        int n;
        n = 0;
        while (o_state !== s && n < 3000) begin
            tick(1);
            n++;
        end
        chk(o_state, s);
    endtask
    task press(input int n);
        btn = 1'b1;
        tick(n);
        btn = 1'b0;
    endtask
    task t_reset(input int n);
        i_rst = 1'b1;
        tick(n);
        i_rst = 1'b0;
        tick(1);
        chk(o_state, BPS_ST_READ_ID);
        chk({o_task.id_read, id_pwr}, 2'h3);
        wait_st(BPS_ST_STANDBY);
        chk({con_en, card_en}, 2'h3);
    endtask
    task t_bad_config;
        dir_ok = 1'b0;
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        chk(o_state, BPS_ST_READ_CFG);
        chk(o_task.cfg_read, 1'b1);
        wait_st(BPS_ST_FIND_DIR);
        chk(o_task.dir_find, 1'b1);
        wait_st(BPS_ST_LOG_FAIL);
        chk(o_task.log_write, 1'b1);
        wait_st(BPS_ST_STANDBY);
        chk(sup_en, 1'b0);
    endtask
    task t_power_up;
        dir_ok = 1'b1;
        press(8);
        wait_st(BPS_ST_CLOCKS_ON);
        chk({sup_en, pm_en, clk_en}, 3'h7);
        wait_st(BPS_ST_PROC_BOOT);
        chk(o_soc.setup_req, 1'b1);
        wait_st(BPS_ST_MEASURE);
        chk({o_soc.ppu_release, o_soc.clusters_on, o_task.supply_measure}, 3'h7);
        wait_st(BPS_ST_SET_OSC);
        chk(o_task.osc_program, 1'b1);
        wait_st(BPS_ST_FLASH);
        chk(o_task.flash_write, 1'b1);
        wait_st(BPS_ST_CFG_RST);
        chk({cfg_n, por_n, sys_n}, 3'h4);
        wait_st(BPS_ST_OPERATING);
        chk({por_n, sys_n}, 2'h3);
    endtask
    task t_sleep_wake;
        press(12);
        wait_st(BPS_ST_SL_CLUSTER);
        chk(o_soc.sleep_req, 1'b1);
        wait_st(BPS_ST_SLEEP);
        chk(o_soc.ram_retain, 1'b1);
        hw_btn = 1'b1;
        os_req = 1'b1;
        press(70);
        hw_btn = 1'b0;
        os_req = 1'b0;
        tick(12);
        chk(o_state, BPS_ST_SLEEP);
        press(12);
        wait_st(BPS_ST_WK_DOMAINS);
        chk({o_soc.clusters_on, o_soc.ram_retain}, 2'h3);
        wait_st(BPS_ST_WK_RESUME);
        chk({o_task.resume_store, o_soc.ppu_release}, 2'h2);
        wait_st(BPS_ST_OPERATING);
    endtask
    task t_power_down(input int kind);
        if (kind == 0) begin
            btn = 1'b1;
            tick(30);
            chk(o_state, BPS_ST_OPERATING);
        end else if (kind == 1) hw_btn = 1'b1;
        else os_req = 1'b1;
        wait_st(BPS_ST_PD_CLUSTER);
        {btn, hw_btn, os_req} = 3'h0;
        chk(o_soc.shutdown_req, 1'b1);
        wait_st(BPS_ST_PD_WAIT_RDY);
        chk(por_n, 1'b1);
        wait_st(BPS_ST_STANDBY);
        chk({por_n, clk_en, pm_en, sup_en}, 4'h0);
    endtask
    initial begin
        {btn, hw_btn, restart, os_req, db_fit, dir_ok} = 6'h00;
        delay = 8'h03;
        fail_count = 0;
        checks = 0;
        t_reset(10);
        t_bad_config();
        t_power_up();
        t_sleep_wake();
        t_power_down(0);
        delay = 8'h14;
        db_fit = 1'b1;
        t_power_up();
        t_power_down(1);
        delay = 8'h00;
        t_power_up();
        t_power_down(2);
        t_reset(3);
        summarize();
    end
    initial begin
        // Own loop: the shared static tick task must not carry two callers at once
        repeat (20000) @(posedge i_clk);
        fail_count++;
        summarize();
    end
endmodule
`default_nettype wire
